// ==== src/nv_data_and_program_access.sv ====
// Controller giving the CPU indirect access to the data array (read/write)
// and to the program flash (read only) through six indexed SFRs.
// Assumes flash data returns combinationally from prog_addr_out, reset
// request inputs are synchronous pulses or levels, and one clock domain.

// Functional notes
// - Data array has 256 bytes, addressed 00h-FFh by the low address alone.
// - Program reads build a 14-bit word and a 13-bit word address.
// - Program flash is 4K or 8K words; single-word reads only.
// - A data byte write first erases the location, then programs it.
// - Write length comes from an internal timer, not from software.
// - Code protection blocks the programmer but never the CPU.
// - Control bit 7 selects data (0, reset) or program (1) space.
// - Program space is read only; write-start does nothing there.
// - Read-start and write-start are set-only; hardware clears them when done.
// - Write permit at bit 2 gates data writes; clear after power-up.
// - Abort flag at bit 3 set by pin, watchdog or brownout reset mid-write.
// - A reset that aborts a write clears data and address registers.
// - Write completion sets the done flag; software clears it.
// - Unlock port has no storage and reads as zero.
// - A data read presents the byte in the low data register next cycle.
// - Low data keeps the read value until another read, a software write or an abort reset.
// - High data implements bits 5-0; bits 7-6 read zero.
// - High address implements bits 4-0; bits 7-5 read zero.
// - Write starts only after 55h then AAh to unlock, then write-start.
// - Write-start blocked while permit is clear; clearing later has no effect.
module nv_data_and_program_access
  import nv_access_pkg::*;
#(
  parameter int PROG_WORDS = PROG_WORDS_DEFAULT,
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEFAULT
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire sfr_req_s sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic ext_reset_pin_in,
  input wire logic watchdog_timeout_in,
  input wire logic brownout_reset_in,
  output logic nv_done_set_out,
  output logic [PROG_ADDR_WIDTH-1:0] prog_addr_out,
  output logic prog_rd_out,
  input wire logic [PROG_WORD_WIDTH-1:0] prog_data_in,
  input wire logic code_protect_in,
  input wire ext_req_s ext_req_in,
  output logic [7:0] ext_rdata_out,
  output logic ext_denied_out
);

  localparam logic [WRITE_COUNT_WIDTH-1:0] WRITE_LAST =
    WRITE_COUNT_WIDTH'(WRITE_CYCLES - 1);
  localparam logic [PROG_ADDR_WIDTH-1:0] PROG_ADDR_MASK =
    PROG_ADDR_WIDTH'(PROG_WORDS - 1);

  // Programmer-visible registers
  logic [7:0] data_low_reg;
  logic [7:0] addr_low_reg;
  logic [7:0] data_high_reg;
  logic [7:0] addr_high_reg;
  logic space_select_reg;
  logic store_abort_flag_reg;
  logic store_permit_reg;
  logic write_start_reg;
  logic read_start_reg;
  logic read_space_reg;

  // Sequencing state
  unlock_e unlock_reg;
  write_e write_state_reg;
  logic [WRITE_COUNT_WIDTH-1:0] write_count_reg;
  logic [7:0] write_addr_reg;
  logic [7:0] write_data_reg;

  // Array connections
  logic arr_wr_en;
  logic [7:0] arr_wr_addr;
  logic [7:0] arr_wr_data;
  logic [7:0] arr_cpu_rdata;
  logic [7:0] arr_ext_rdata;

  // Decoded events
  logic abort_reset;
  logic ctl_wr;
  logic unlock_wr;
  logic write_go;
  logic write_done;

  // Folds the two address bytes into a word address inside the fitted flash
  function automatic logic [PROG_ADDR_WIDTH-1:0] prog_word_addr(
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic [15:0] full;
    full = {hi & ADDR_HIGH_MASK, lo};
    return full[PROG_ADDR_WIDTH-1:0] & PROG_ADDR_MASK;
  endfunction

  // Tests whether the current SFR access is a write to one register
  function automatic logic reg_write(input sfr_req_s req, input logic [2:0] idx);
    return req.wr && (req.idx == idx);
  endfunction

  // Any non-power-on reset source; these also abort a write in flight
  assign abort_reset = ext_reset_pin_in | watchdog_timeout_in | brownout_reset_in;
  assign ctl_wr = reg_write(sfr_req_in, IDX_CONTROL);
  assign unlock_wr = reg_write(sfr_req_in, IDX_UNLOCK);

  // A write starts only when armed, permitted, idle and aimed at data space
  assign write_go = ctl_wr && sfr_req_in.wdata[CTL_WRITE_BIT]
    && (unlock_reg == UNL_ARMED)
    && store_permit_reg
    && !sfr_req_in.wdata[CTL_SPACE_BIT]
    && (write_state_reg == WR_IDLE) && !abort_reset;
  assign write_done = (write_state_reg == WR_BUSY) && (write_count_reg == '0)
    && !abort_reset;

  // Unlock tracker: any write other than the exact sequence disarms it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unlock_reg <= UNL_IDLE;
    end else if (abort_reset) begin
      unlock_reg <= UNL_IDLE;
    end else if (sfr_req_in.wr) begin
      case (unlock_reg)
        UNL_IDLE: begin
          unlock_reg <= (unlock_wr && sfr_req_in.wdata == UNLOCK_KEY_FIRST)
            ? UNL_GOT_FIRST : UNL_IDLE;
        end
        UNL_GOT_FIRST: begin
          unlock_reg <= (unlock_wr && sfr_req_in.wdata == UNLOCK_KEY_SECOND)
            ? UNL_ARMED : UNL_IDLE;
        end
        UNL_ARMED: begin
          unlock_reg <= UNL_IDLE; // One write-start per sequence
        end
        default: begin
          unlock_reg <= UNL_IDLE;
        end
      endcase
    end
  end

  // Self-timed write: erase on entry, program on the last count
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      write_state_reg <= WR_IDLE;
      write_count_reg <= '0;
      write_addr_reg <= REG_RESET;
      write_data_reg <= REG_RESET;
    end else begin
      case (write_state_reg)
        WR_IDLE: begin
          if (write_go) begin
            write_state_reg <= WR_BUSY;
            write_count_reg <= WRITE_LAST;
            write_addr_reg <= addr_low_reg;
            write_data_reg <= data_low_reg;
          end
        end
        WR_BUSY: begin
          if (abort_reset || write_count_reg == '0) begin
            write_state_reg <= WR_IDLE;
          end else begin
            write_count_reg <= write_count_reg - 1'b1;
          end
        end
        default: begin
          write_state_reg <= WR_IDLE;
        end
      endcase
    end
  end

  // Array write port: erase byte at start, final value at completion
  always_comb begin
    arr_wr_en = 1'b0;
    arr_wr_addr = write_addr_reg;
    arr_wr_data = write_data_reg;
    if (write_go) begin
      arr_wr_en = 1'b1;
      arr_wr_addr = addr_low_reg;
      arr_wr_data = ERASED_BYTE;
    end else if (write_done) begin
      arr_wr_en = 1'b1;
    end
  end

  // Control bits; set-only bits ignore software zeros
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      space_select_reg <= 1'b0;
      store_permit_reg <= 1'b0;
      write_start_reg <= 1'b0;
      read_start_reg <= 1'b0;
      read_space_reg <= 1'b0;
    end else if (abort_reset) begin
      space_select_reg <= 1'b0;
      store_permit_reg <= 1'b0;
      write_start_reg <= 1'b0;
      read_start_reg <= 1'b0;
      read_space_reg <= 1'b0;
    end else begin
      if (ctl_wr) begin
        space_select_reg <= sfr_req_in.wdata[CTL_SPACE_BIT];
        store_permit_reg <= sfr_req_in.wdata[CTL_PERMIT_BIT];
      end
      // Held for the whole timed cycle, dropped by the sequencer or by an abort reset
      if (write_go) begin
        write_start_reg <= 1'b1;
      end else if (write_done) begin
        write_start_reg <= 1'b0;
      end
      // Read completes in one cycle, so a set is always followed by a clear
      if (ctl_wr && sfr_req_in.wdata[CTL_READ_BIT] && !read_start_reg) begin
        read_start_reg <= 1'b1;
        read_space_reg <= sfr_req_in.wdata[CTL_SPACE_BIT];
      end else begin
        read_start_reg <= 1'b0;
      end
    end
  end

  // Abort flag: set by a reset that cuts a write short, cleared on a clean finish
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      store_abort_flag_reg <= 1'b0;
    end else if (abort_reset && write_state_reg == WR_BUSY) begin
      store_abort_flag_reg <= 1'b1;
    end else if (write_done) begin
      store_abort_flag_reg <= 1'b0;
    end else if (ctl_wr) begin
      store_abort_flag_reg <= sfr_req_in.wdata[CTL_ABORT_BIT];
    end
  end

  // Address registers; unimplemented high bits never store
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_low_reg <= REG_RESET;
      addr_high_reg <= REG_RESET;
    end else if (abort_reset) begin
      addr_low_reg <= REG_RESET;
      addr_high_reg <= REG_RESET;
    end else begin
      if (reg_write(sfr_req_in, IDX_ADDR_LOW)) begin
        addr_low_reg <= sfr_req_in.wdata;
      end
      if (reg_write(sfr_req_in, IDX_ADDR_HIGH)) begin
        addr_high_reg <= sfr_req_in.wdata & ADDR_HIGH_MASK;
      end
    end
  end

  // Data registers; a finishing read beats a software write in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_low_reg <= REG_RESET;
      data_high_reg <= REG_RESET;
    end else if (abort_reset) begin
      data_low_reg <= REG_RESET;
      data_high_reg <= REG_RESET;
    end else if (read_start_reg && !read_space_reg) begin
      data_low_reg <= arr_cpu_rdata;
    end else if (read_start_reg && read_space_reg) begin
      data_low_reg <= prog_data_in[7:0];
      data_high_reg <= {2'b00, prog_data_in[PROG_WORD_WIDTH-1:8]};
    end else begin
      if (reg_write(sfr_req_in, IDX_DATA_LOW)) begin
        data_low_reg <= sfr_req_in.wdata;
      end
      if (reg_write(sfr_req_in, IDX_DATA_HIGH)) begin
        data_high_reg <= sfr_req_in.wdata & DATA_HIGH_MASK;
      end
    end
  end

  // Flash address follows the address bytes; strobe marks the read cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prog_addr_out <= '0;
      prog_rd_out <= 1'b0;
    end else begin
      prog_addr_out <= prog_word_addr(addr_high_reg, addr_low_reg);
      prog_rd_out <= ctl_wr && sfr_req_in.wdata[CTL_READ_BIT]
        && sfr_req_in.wdata[CTL_SPACE_BIT] && !read_start_reg && !abort_reset;
    end
  end

  // One-cycle completion pulse toward the peripheral flag register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nv_done_set_out <= 1'b0;
    end else begin
      nv_done_set_out <= write_done;
    end
  end

  // SFR read data, registered; the unlock port and unmapped slots read zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sfr_rdata_out <= REG_RESET;
    end else if (!sfr_req_in.rd) begin
      sfr_rdata_out <= REG_RESET;
    end else if (sfr_req_in.idx == IDX_DATA_LOW) begin
      sfr_rdata_out <= data_low_reg;
    end else if (sfr_req_in.idx == IDX_ADDR_LOW) begin
      sfr_rdata_out <= addr_low_reg;
    end else if (sfr_req_in.idx == IDX_DATA_HIGH) begin
      sfr_rdata_out <= data_high_reg & DATA_HIGH_MASK;
    end else if (sfr_req_in.idx == IDX_ADDR_HIGH) begin
      sfr_rdata_out <= addr_high_reg & ADDR_HIGH_MASK;
    end else if (sfr_req_in.idx == IDX_CONTROL) begin
      sfr_rdata_out <= {space_select_reg, 3'b000, store_abort_flag_reg,
        store_permit_reg, write_start_reg, read_start_reg};
    end else begin
      sfr_rdata_out <= REG_RESET;
    end
  end

  // Programmer port: refused while code protection is on, CPU path unaffected
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_rdata_out <= REG_RESET;
      ext_denied_out <= 1'b0;
    end else if (ext_req_in.rd) begin
      ext_rdata_out <= code_protect_in ? REG_RESET : arr_ext_rdata;
      ext_denied_out <= code_protect_in;
    end else begin
      ext_denied_out <= 1'b0;
    end
  end

  nv_byte_array #(
    .DEPTH(DATA_DEPTH),
    .WIDTH(DATA_WIDTH)
  ) u_data_array (
    .clk_in(clk_in),
    .wr_en_in(arr_wr_en),
    .wr_addr_in(arr_wr_addr),
    .wr_data_in(arr_wr_data),
    .rd_addr_a_in(addr_low_reg),
    .rd_data_a_out(arr_cpu_rdata),
    .rd_addr_b_in(ext_req_in.addr),
    .rd_data_b_out(arr_ext_rdata)
  );

endmodule // nv_data_and_program_access

// ==== src/nv_access_pkg.sv ====
// Package for the nonvolatile access controller: register indices, field
// positions, reset values, unlock keys and shared types.
// Assumes a single CPU instruction clock and an SFR port of indexed registers.
package nv_access_pkg;

  // Register indices on the SFR port
  localparam logic [2:0] IDX_DATA_LOW = 3'h0;
  localparam logic [2:0] IDX_ADDR_LOW = 3'h1;
  localparam logic [2:0] IDX_DATA_HIGH = 3'h2;
  localparam logic [2:0] IDX_ADDR_HIGH = 3'h3;
  localparam logic [2:0] IDX_CONTROL = 3'h4;
  localparam logic [2:0] IDX_UNLOCK = 3'h5;

  // Control register fields
  localparam int CTL_SPACE_BIT = 7;
  localparam int CTL_ABORT_BIT = 3;
  localparam int CTL_PERMIT_BIT = 2;
  localparam int CTL_WRITE_BIT = 1;
  localparam int CTL_READ_BIT = 0;

  // Implemented bits of the high registers
  localparam logic [7:0] DATA_HIGH_MASK = 8'h3F;
  localparam logic [7:0] ADDR_HIGH_MASK = 8'h1F;

  // Reset and erased-byte values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Unlock sequence keys
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

  // Array geometry and word widths
  localparam int DATA_DEPTH = 256;
  localparam int DATA_WIDTH = 8;
  localparam int PROG_WORD_WIDTH = 14;
  localparam int PROG_ADDR_WIDTH = 13;
  localparam int PROG_WORDS_DEFAULT = 8192;

  // Self-timed write length in instruction clocks
  localparam int WRITE_CYCLES_DEFAULT = 1000;
  localparam int WRITE_COUNT_WIDTH = 16;

  // One CPU access to the SFR port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] idx;
    logic [7:0] wdata;
  } sfr_req_s;

  // Programmer-side read request to the data array
  typedef struct packed {
    logic rd;
    logic [7:0] addr;
  } ext_req_s;

  // Progress of the unlock sequence
  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_GOT_FIRST,
    UNL_ARMED
  } unlock_e;

  // Self-timed write sequencer
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_BUSY
  } write_e;

endpackage

// ==== src/nv_byte_array.sv ====
// Byte-wide data array with one write port and two combinational read ports.
// Assumes writes are qualified by the controller; contents have no reset.
module nv_byte_array #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_a_in,
  output logic [WIDTH-1:0] rd_data_a_out,
  input wire logic [AW-1:0] rd_addr_b_in,
  output logic [WIDTH-1:0] rd_data_b_out
);

  logic [WIDTH-1:0] cells [DEPTH];

  // Storage is nonvolatile in intent, so reset leaves it alone
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      cells[wr_addr_in] <= wr_data_in;
    end
  end

  // Read ports are flow-through; the controller registers what it needs
  assign rd_data_a_out = cells[rd_addr_a_in];
  assign rd_data_b_out = cells[rd_addr_b_in];

endmodule // nv_byte_array

// ==== sim/nv_access_sva.sv ====
// Checker for the nonvolatile access controller, bound to its top module.
// Assumes one clock domain and the asynchronous active-low power-on reset.
module nv_access_sva
  import nv_access_pkg::*;
#(
  parameter int PROG_WORDS = PROG_WORDS_DEFAULT,
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEFAULT
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire sfr_req_s sfr_req_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic ext_reset_pin_in,
  input wire logic watchdog_timeout_in,
  input wire logic brownout_reset_in,
  input wire logic nv_done_set_out,
  input wire logic [PROG_ADDR_WIDTH-1:0] prog_addr_out,
  input wire logic prog_rd_out,
  input wire logic [PROG_WORD_WIDTH-1:0] prog_data_in,
  input wire logic code_protect_in,
  input wire ext_req_s ext_req_in,
  input wire logic [7:0] ext_rdata_out,
  input wire logic ext_denied_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] since_start_reg;

  // Cycles since the last control write asking for a write; saturates so it never wraps
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      since_start_reg <= 16'h0000;
    end else if (sfr_req_in.wr && sfr_req_in.idx == IDX_CONTROL && sfr_req_in.wdata[1]) begin
      since_start_reg <= 16'h0001;
    end else if (since_start_reg != 16'h0000 && since_start_reg != 16'hFFFF) begin
      since_start_reg <= since_start_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_unlock_zero: assert property (sfr_req_in.rd && sfr_req_in.idx == IDX_UNLOCK
    |=> sfr_rdata_out == 8'h00) else $error("unlock port read not zero");
  chk_dhigh_mask: assert property (sfr_req_in.rd && sfr_req_in.idx == IDX_DATA_HIGH
    |=> sfr_rdata_out[7:6] == 2'b00) else $error("data high upper bits not zero");
  chk_ahigh_mask: assert property (sfr_req_in.rd && sfr_req_in.idx == IDX_ADDR_HIGH
    |=> sfr_rdata_out[7:5] == 3'b000) else $error("address high upper bits not zero");
  chk_prog_single: assert property (prog_rd_out |=> !prog_rd_out)
    else $error("flash read longer than one cycle");
  chk_prog_cause: assert property ($rose(prog_rd_out) |-> $past(sfr_req_in.wr
    && sfr_req_in.idx == IDX_CONTROL && sfr_req_in.wdata[7] && sfr_req_in.wdata[0]))
    else $error("flash read without program-space read start");
  chk_done_pulse: assert property (nv_done_set_out |=> !nv_done_set_out)
    else $error("done pulse longer than one cycle");
  chk_done_timing: assert property (nv_done_set_out
    |-> since_start_reg >= WRITE_CYCLES + 1) else $error("write finished too early");
  chk_ext_denied: assert property (ext_req_in.rd && code_protect_in
    |=> ext_denied_out && ext_rdata_out == 8'h00) else $error("protected read not refused");
  chk_ext_allowed: assert property (ext_req_in.rd && !code_protect_in
    |=> !ext_denied_out) else $error("unprotected read refused");
endmodule // nv_access_sva

// ==== sim/tb_top.sv ====
// Self-checking bench for the nonvolatile access controller.
// Drives every port itself; the flash is a combinational pattern of its address.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nv_access_pkg::*;
  localparam int WC = 8;
  localparam logic [7:0] BAD_K1 [4] = '{8'h55, 8'hAA, 8'h55, 8'h55};
  localparam logic [7:0] BAD_K2 [4] = '{8'hAA, 8'h55, 8'h55, 8'hAA};
  localparam logic [7:0] BAD_CTL [4] = '{8'h02, 8'h06, 8'h06, 8'h86};
  logic clk_in, rst_b_in, code_protect_in, nv_done_set_out, prog_rd_out, ext_denied_out;
  sfr_req_s sfr_req_in;
  ext_req_s ext_req_in;
  logic [2:0] abort_vec;
  logic [7:0] sfr_rdata_out, ext_rdata_out, rd_v, a, d;
  logic [7:0] mem [256];
  logic [12:0] prog_addr_out, ma;
  logic [13:0] prog_data_in, w;
  logic [15:0] pa;
  int err_total, n_checks, cyc, dones, n;

  nv_data_and_program_access #(.PROG_WORDS(4096), .WRITE_CYCLES(WC)) dut (
    .clk_in, .rst_b_in, .sfr_req_in, .sfr_rdata_out,
    .ext_reset_pin_in(abort_vec[0]), .watchdog_timeout_in(abort_vec[1]),
    .brownout_reset_in(abort_vec[2]), .nv_done_set_out, .prog_addr_out, .prog_rd_out,
    .prog_data_in, .code_protect_in, .ext_req_in, .ext_rdata_out, .ext_denied_out);

  // Flash answers at once, as the controller expects
  assign prog_data_in = {prog_addr_out[0], prog_addr_out} ^ 14'h2A5B;

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Done pulses are counted here so no wait can miss one; a hang ends the run
  always @(posedge clk_in) begin
    if (nv_done_set_out === 1'b1) dones++;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [2:0] i, logic [7:0] v);
    @(posedge clk_in);
    sfr_req_in <= '{wr: 1'b1, rd: 1'b0, idx: i, wdata: v};
    @(posedge clk_in);
    sfr_req_in <= '0;
  endtask

  // Read data is registered, so it is taken just after the edge that took the read
  task automatic rd(logic [2:0] i);
    @(posedge clk_in);
    sfr_req_in <= '{wr: 1'b0, rd: 1'b1, idx: i, wdata: 8'h00};
    @(posedge clk_in);
    sfr_req_in <= '0;
    #1 rd_v = sfr_rdata_out;
  endtask

  task automatic store(logic [7:0] aa, logic [7:0] dd);
    wr(IDX_ADDR_LOW, aa);
    wr(IDX_DATA_LOW, dd);
    // Abort bit written as zero, so a later abort readback proves the hardware set
    wr(IDX_CONTROL, 8'h04);
    wr(IDX_UNLOCK, UNLOCK_KEY_FIRST);
    wr(IDX_UNLOCK, UNLOCK_KEY_SECOND);
    wr(IDX_CONTROL, 8'h06);
  endtask

  task automatic fetch(logic [7:0] aa);
    wr(IDX_ADDR_LOW, aa);
    wr(IDX_CONTROL, 8'h01);
    rd(IDX_DATA_LOW);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rst_b_in = 1'b0;
    code_protect_in = 1'b0;
    sfr_req_in = '0;
    ext_req_in = '0;
    abort_vec = 3'b000;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    dones = 0;
    void'($urandom(32'hD78AD1AF));
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // Reset values, the unmapped index included
    for (int i = 0; i < 6; i++) begin
      rd(3'(i));
      chk("reset value", REG_RESET, rd_v);
    end
    rd(3'h6);
    chk("unmapped index", REG_RESET, rd_v);
    // Each abort source cuts a write short after the erase
    for (int k = 0; k < 3; k++) begin
      a = 8'($urandom);
      n = dones;
      store(a, 8'h5A);
      repeat (3) @(posedge clk_in);
      abort_vec <= 3'(1 << k);
      @(posedge clk_in);
      abort_vec <= 3'b000;
      rd(IDX_CONTROL);
      chk("abort control", 8'h08, rd_v);
      rd(IDX_ADDR_LOW);
      chk("abort address", 8'h00, rd_v);
      rd(IDX_DATA_LOW);
      chk("abort data", 8'h00, rd_v);
      repeat (WC + 4) @(posedge clk_in);
      chk("abort done count", 8'(n), 8'(dones));
      fetch(a);
      chk("aborted byte", ERASED_BYTE, rd_v);
    end
    // Full writes at both ends of the array and at random places
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      n = dones;
      store(a, d);
      wr(IDX_CONTROL, 8'h08);
      rd(IDX_CONTROL);
      chk("busy control", 8'h0A, rd_v);
      repeat (WC + 20) @(posedge clk_in);
      chk("done count", 8'(n + 1), 8'(dones));
      rd(IDX_CONTROL);
      chk("control after write", 8'h00, rd_v);
      mem[a] = d;
      fetch(a);
      chk("read back", d, rd_v);
      rd(IDX_DATA_LOW);
      chk("data held", d, rd_v);
      rd(IDX_CONTROL);
      chk("read start clears", 8'h00, rd_v);
    end
    // Writes that must be refused: no permit, wrong keys, program space
    for (int k = 0; k < 4; k++) begin
      wr(IDX_ADDR_LOW, a);
      wr(IDX_DATA_LOW, ~mem[a]);
      wr(IDX_CONTROL, BAD_CTL[k] & 8'hFD);
      wr(IDX_UNLOCK, BAD_K1[k]);
      wr(IDX_UNLOCK, BAD_K2[k]);
      n = dones;
      wr(IDX_CONTROL, BAD_CTL[k]);
      repeat (WC + 20) @(posedge clk_in);
      chk("refused done count", 8'(n), 8'(dones));
      fetch(a);
      chk("refused byte", mem[a], rd_v);
    end
    // Program reads, top address first; upper bits beyond the array are dropped
    for (int k = 0; k < 3; k++) begin
      pa = (k == 0) ? 16'hFFFF : 16'($urandom);
      ma = pa[12:0] & 13'h0FFF;
      w = {ma[0], ma} ^ 14'h2A5B;
      wr(IDX_ADDR_HIGH, pa[15:8]);
      wr(IDX_ADDR_LOW, pa[7:0]);
      wr(IDX_CONTROL, 8'h81);
      rd(IDX_DATA_LOW);
      chk("program low", w[7:0], rd_v);
      rd(IDX_DATA_HIGH);
      chk("program high", {2'b00, w[13:8]}, rd_v);
      rd(IDX_ADDR_HIGH);
      chk("address high", pa[15:8] & ADDR_HIGH_MASK, rd_v);
      chk("flash address low", ma[7:0], prog_addr_out[7:0]);
      chk("flash address high", {3'b000, ma[12:8]}, {3'b000, prog_addr_out[12:8]});
    end
    // Programmer reads with and without protection, then the CPU still reads
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      code_protect_in <= k[0];
      ext_req_in <= '{rd: 1'b1, addr: a};
      @(posedge clk_in);
      ext_req_in <= '0;
      #1;
      chk("programmer data", k[0] ? 8'h00 : mem[a], ext_rdata_out);
      chk("programmer refusal", {7'h00, k[0]}, {7'h00, ext_denied_out});
    end
    fetch(a);
    chk("protected cpu read", mem[a], rd_v);
    final_report();
  end
endmodule // tb_top

bind nv_data_and_program_access nv_access_sva #(
  .PROG_WORDS(PROG_WORDS), .WRITE_CYCLES(WRITE_CYCLES)) sva_i (
  .clk_in, .rst_b_in, .sfr_req_in, .sfr_rdata_out, .ext_reset_pin_in, .watchdog_timeout_in,
  .brownout_reset_in, .nv_done_set_out, .prog_addr_out, .prog_rd_out, .prog_data_in,
  .code_protect_in, .ext_req_in, .ext_rdata_out, .ext_denied_out);
